// file: eep_cpu_model.sv
module eep_cpu_model
    import eep_pkg::*;
(
    input  wire logic clk,
    output eep_req_t  bus_req,
    output eep_ctrl_t ctrl_wr
);
    timeunit 1ns;
    timeprecision 1ns;
    // No fetch port: only data reads and writes are issued
    initial begin
        bus_req = '0;
        ctrl_wr = '0;
    end
    task automatic ctl(input logic le, input logic ps);
        @(negedge clk) ctrl_wr = '{1'b1, le, ps};
        @(negedge clk) ctrl_wr.we = 1'b0;
    endtask
    // Callers keep the row bits fixed between cycles
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk) bus_req = '{1'b0, 1'b1, a, d};
        // Released data shows the inverse so stale bytes never match
        @(negedge clk) bus_req = '{1'b0, 1'b0, a, ~d};
    endtask
    task automatic rd(input logic [6:0] a);
        @(negedge clk) bus_req = '{1'b1, 1'b0, a, 8'h00};
        #10;
    endtask
endmodule

// file: eep_pkg.sv
package eep_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } eep_req_t;

    typedef struct packed {
        logic we;
        logic latch_en;
        logic prog_start;
    } eep_ctrl_t;

    typedef enum logic [0:0] {
        EEP_IDLE = 1'b0,
        EEP_PROG = 1'b1
    } eep_state_t;
endpackage

// file: eep_regs.svh
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH
// Notes on behaviour
// - Latch enable clear: array reads like ROM.
// - Read data appears within the same cycle.
// - Write mode: byte goes to latch by low bits.
// - Program start commits all captured latches at once.
// - Row comes from the last captured write address.
// - Cycle end clears both controls together.
// - Repeated writes AND into the same latch.
// - Latches clear at cycle end, enable falling edge.
// - Reads never return latch contents.
`define EEP_ADDR_W      7
`define EEP_COL_W       5
`define EEP_ROW_BYTES   32
`define EEP_ERASED      8'hFF
`define EEP_PROG_NS     1000
`define EEP_CLK_NS      100
`define EEP_PROG_CYC    ((`EEP_PROG_NS + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`endif

// file: eep_row_programmer.sv
`include "eep_regs.svh"

module eep_row_programmer
    import eep_pkg::*;
#(
    parameter int ADDR_W    = `EEP_ADDR_W,
    parameter int COL_W     = `EEP_COL_W,
    parameter int PROG_CYC  = `EEP_PROG_CYC
) (
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire eep_req_t  bus_req,
    output logic [7:0]     bus_rdata,
    input  wire eep_ctrl_t ctrl_wr,
    output logic           write_latch_enable,
    output logic           program_start
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int ROWB  = 1 << COL_W;
    localparam int ROW_W = ADDR_W - COL_W;
    localparam int CNT_W = $clog2(PROG_CYC + 1);

    // Column that picks the latch inside a row
    function automatic logic [COL_W-1:0] col_of(
        input logic [ADDR_W-1:0] addr
    );
        return addr[COL_W-1:0];
    endfunction

    // Row that all latches of one cycle land in
    function automatic logic [ROW_W-1:0] row_of(
        input logic [ADDR_W-1:0] addr
    );
        return addr[ADDR_W-1:COL_W];
    endfunction

    function automatic logic [ADDR_W-1:0] cell_at(
        input logic [ROW_W-1:0] row,
        input logic [COL_W-1:0] col
    );
        return {row, col};
    endfunction

    function automatic logic lane_match(
        input logic [COL_W-1:0] col,
        input int               lane
    );
        return col == COL_W'(lane);
    endfunction

    logic [7:0]       cells_q   [DEPTH];
    logic [7:0]       latch_q   [ROWB];
    logic [7:0]       latch_d   [ROWB];
    logic [ROWB-1:0]  used_q;
    logic [ROWB-1:0]  used_d;
    logic [ROWB-1:0]  lane_hit;
    logic [ROWB-1:0]  lane_prog;

    logic [ROW_W-1:0] row_q;
    logic [ROW_W-1:0] row_d;
    logic             lat_q;
    logic             lat_d;
    logic             pgm_q;
    logic             pgm_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    eep_state_t       state_q;
    eep_state_t       state_d;

    // State decode
    wire             is_idle   = (state_q == EEP_IDLE);
    wire             is_prog   = (state_q == EEP_PROG);

    // Bus side decode
    wire [COL_W-1:0] wr_col    = col_of(bus_req.addr);
    wire [ROW_W-1:0] wr_row    = row_of(bus_req.addr);
    wire             capture   = bus_req.wr & lat_q & is_idle;

    // Control writes
    wire             ctl_write = ctrl_wr.we;
    wire             sw_abort  = ctl_write & ~ctrl_wr.latch_en;
    wire             ctl_take  = ctl_write & is_idle;
    // Start only once write mode is already up, never in the same write
    wire             start     = ctl_write & ctrl_wr.latch_en
                                 & ctrl_wr.prog_start & lat_q
                                 & is_idle;

    // Cycle timing
    wire             last_tick = (cnt_q == CNT_W'(PROG_CYC - 1));
    wire             prog_done = is_prog & last_tick;
    wire             cycle_end = prog_done | sw_abort;
    // Aborting mid cycle leaves the cells untouched; integrity is kept
    wire             lat_fall  = lat_q & sw_abort;
    wire             clr_latch = prog_done | lat_fall;

    // Array read straight from the cells, no wait states
    assign bus_rdata          = cells_q[bus_req.addr];
    assign write_latch_enable = lat_q;
    assign program_start      = pgm_q;

    // Idle until a valid start, back when the cycle ends
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            EEP_IDLE: begin
                if (start) begin
                    state_d = EEP_PROG;
                end
            end
            EEP_PROG: begin
                if (cycle_end) begin
                    state_d = EEP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= EEP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Counter runs only inside a cycle and rests at zero
    always_comb begin
        cnt_d = '0;
        if (is_prog) begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Ending or aborting a cycle wins over any control write
    always_comb begin
        lat_d = lat_q;
        pgm_d = pgm_q;
        if (cycle_end) begin
            lat_d = 1'b0;
            pgm_d = 1'b0;
        end else if (ctl_take) begin
            lat_d = ctrl_wr.latch_en;
            pgm_d = start;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lat_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pgm_q <= 1'b0;
        end else begin
            pgm_q <= pgm_d;
        end
    end

    // Row follows the latest captured write; software keeps it fixed
    assign row_d = capture ? wr_row : row_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            row_q <= '0;
        end else begin
            row_q <= row_d;
        end
    end

    // One byte latch per column
    generate
        for (genvar i = 0; i < ROWB; i++) begin : g_lane
            assign lane_hit[i]  = capture && lane_match(wr_col, i);
            assign lane_prog[i] = prog_done && used_q[i];
            // Latch bytes only lose ones until cleared, so rewrites AND
            assign latch_d[i]   = clr_latch   ? `EEP_ERASED
                                : lane_hit[i] ? (latch_q[i] & bus_req.wdata)
                                : latch_q[i];
            assign used_d[i]    = clr_latch   ? 1'b0
                                : lane_hit[i] ? 1'b1
                                : used_q[i];

            always_ff @(posedge clk) begin
                if (rst) begin
                    latch_q[i] <= `EEP_ERASED;
                end else begin
                    latch_q[i] <= latch_d[i];
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    used_q[i] <= 1'b0;
                end else begin
                    used_q[i] <= used_d[i];
                end
            end
        end
    endgenerate

    // Cells keep their content across reset, like the real array
    always_ff @(posedge clk) begin
        for (int i = 0; i < ROWB; i++) begin
            if (lane_prog[i]) begin
                cells_q[cell_at(row_q, COL_W'(i))] <= latch_q[i];
            end
        end
    end
endmodule

// file: eep_row_programmer_props.sv
module eep_row_programmer_props
    import eep_pkg::*;
#(
    parameter int PROG_CYC = 10
) (
    input wire logic      clk,
    input wire logic      rst,
    input wire eep_ctrl_t ctrl_wr,
    input wire logic      write_latch_enable,
    input wire logic      program_start
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_go;
        ctrl_wr.we && ctrl_wr.latch_en && ctrl_wr.prog_start
            && write_latch_enable && !program_start;
    endsequence
    a_start_taken: assert property (s_go |=> program_start)
        else $error("start ignored");
    a_cycle_ends: assert property (s_go |=> ##[1:PROG_CYC]
        !program_start) else $error("cycle too long");
    a_both_clear: assert property ($fell(program_start) |->
        !write_latch_enable) else $error("enable left set");
    a_start_no_en: assert property (ctrl_wr.we && ctrl_wr.prog_start
        && !write_latch_enable |=> !program_start) else $error("bad start");
    a_abort_clears: assert property (ctrl_wr.we && !ctrl_wr.latch_en
        |=> !write_latch_enable) else $error("enable not cleared");
    a_en_holds: assert property (write_latch_enable && !program_start
        && !ctrl_wr.we |=> write_latch_enable) else $error("enable lost");
    a_idle_stays: assert property (!write_latch_enable && !ctrl_wr.we
        |=> !write_latch_enable && !program_start) else $error("woke up");
    a_en_set: assert property (ctrl_wr.we && ctrl_wr.latch_en
        && !ctrl_wr.prog_start && !program_start |=> write_latch_enable)
        else $error("enable not set");
endmodule

// file: eep_row_programmer_tb_top.sv
module eep_row_programmer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import eep_pkg::*;
    localparam int PROG_N = 2;
    logic       clk;
    logic       rst;
    eep_req_t   bus_req;
    eep_ctrl_t  ctrl_wr;
    logic [7:0] bus_rdata;
    logic       write_latch_enable;
    logic       program_start;
    int         fail_count = 0;
    int         tests_run = 0;
    eep_cpu_model cpu_u (.clk(clk), .bus_req(bus_req), .ctrl_wr(ctrl_wr));
    eep_row_programmer #(.PROG_CYC(PROG_N)) dut_u (.clk(clk), .rst(rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .ctrl_wr(ctrl_wr),
        .write_latch_enable(write_latch_enable),
        .program_start(program_start));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h", $time, g);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        cpu_u.rd(a);
        chk(bus_rdata, e);
    endtask
    task automatic commit();
        int n;
        cpu_u.ctl(1'b1, 1'b1);
        for (n = 0; n < 20 && program_start !== 1'b0; n++) @(negedge clk);
        chk(8'(n), 8'(PROG_N));
        chk({7'h00, program_start}, 8'h00);
        chk({7'h00, write_latch_enable}, 8'h00);
    endtask
    task automatic t_row();
        cpu_u.ctl(1'b1, 1'b0);
        cpu_u.wr(7'h25, 8'h5A);
        cpu_u.wr(7'h25, 8'h3C);
        cpu_u.wr(7'h26, 8'h81);
        commit();
        rd_chk(7'h25, 8'h18);
        rd_chk(7'h26, 8'h81);
    endtask
    task automatic t_refuse();
        cpu_u.ctl(1'b0, 1'b1);
        chk({7'h00, program_start}, 8'h00);
        cpu_u.wr(7'h25, 8'h00);
        cpu_u.ctl(1'b1, 1'b1);
        chk({7'h00, program_start}, 8'h00);
        chk({7'h00, write_latch_enable}, 8'h01);
        cpu_u.wr(7'h24, 8'h11);
        commit();
        rd_chk(7'h25, 8'h18);
        rd_chk(7'h24, 8'h11);
    endtask
    task automatic t_abort();
        cpu_u.ctl(1'b1, 1'b0);
        cpu_u.wr(7'h25, 8'h00);
        rd_chk(7'h25, 8'h18);
        cpu_u.ctl(1'b0, 1'b0);
        cpu_u.ctl(1'b1, 1'b0);
        cpu_u.wr(7'h27, 8'h7E);
        commit();
        rd_chk(7'h25, 8'h18);
        rd_chk(7'h27, 8'h7E);
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_row();
        t_refuse();
        t_abort();
        print_verdict();
    end
endmodule
bind eep_row_programmer eep_row_programmer_props #(.PROG_CYC(PROG_CYC))
    props_u (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
    .write_latch_enable(write_latch_enable), .program_start(program_start));
